// ==== hdl/dmp_channel.sv ====
// Purpose: One direct memory processor channel with address, count and chain.
// Assumes: step is a one-cycle pulse after each word moved.
// Notes: A chained block is armed by writing the next count.
module dmp_channel
    import party_line_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wr,
    input wire logic [2:0] wr_field,
    input wire logic [15:0] wr_data,
    input wire logic step,
    output logic [15:0] addr,
    output logic [15:0] count,
    output logic [10:0] ctrl,
    output logic chain_armed,
    output logic block_end
);

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] count;
        logic [10:0] ctrl;
        logic [15:0] naddr;
        logic [15:0] ncount;
        logic nvalid;
        logic block_end;
    } ch_state_t;

    ch_state_t ch_reg;
    ch_state_t ch_next;

    always_comb begin
        ch_next = ch_reg;
        ch_next.block_end = 1'b0;
        if (step) begin
            ch_next.addr = ch_reg.addr + 16'h0001;
            ch_next.count = ch_reg.count - 16'h0001;
            if (ch_reg.count == 16'h0001) begin
                ch_next.block_end = 1'b1;
                if (ch_reg.ctrl[CTL_CHAIN] && ch_reg.nvalid) begin
                    ch_next.addr = ch_reg.naddr;
                    ch_next.count = ch_reg.ncount;
                    ch_next.nvalid = 1'b0;
                end
            end
        end
        if (wr) begin
            unique case (wr_field)
                CH_ADDR: ch_next.addr = wr_data;
                CH_COUNT: ch_next.count = wr_data;
                CH_CTRL: ch_next.ctrl = wr_data[10:0];
                CH_NADDR: ch_next.naddr = wr_data;
                CH_NCOUNT: begin
                    ch_next.ncount = wr_data;
                    ch_next.nvalid = wr_data != 16'h0000;
                end
                default: ch_next.ctrl = ch_reg.ctrl;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ch_reg <= '{ctrl: CTL_RESET, default: '0};
        end else begin
            ch_reg <= ch_next;
        end
    end

    assign addr = ch_reg.addr;
    assign count = ch_reg.count;
    assign ctrl = ch_reg.ctrl;
    assign chain_armed = ch_reg.nvalid;
    assign block_end = ch_reg.block_end;

    property p_step_moves;
        @(posedge sys_clk) disable iff (srst)
        (step && !wr && count > 16'h0001) |=>
            (count == $past(count) - 16'h0001) && (addr == $past(addr) + 16'h0001);
    endproperty
    a_step_moves: assert property (p_step_moves) else $error("channel did not advance");

    property p_chain_load;
        @(posedge sys_clk) disable iff (srst)
        (step && !wr && count == 16'h0001 && ctrl[CTL_CHAIN] && chain_armed) |=>
            (count == $past(ch_reg.ncount)) && block_end && !chain_armed;
    endproperty
    a_chain_load: assert property (p_chain_load) else $error("chain block not loaded");

endmodule : dmp_channel

// ==== hdl/fixed_prio_pick.sv ====
// Purpose: Picks the lowest-numbered requester.
// Assumes: Requests are levels sampled by the caller.
// Notes: Purely combinational.
module fixed_prio_pick
    import party_line_pkg::*;
#(
    parameter int N = 8
) (
    input wire logic [N-1:0] req,
    output logic any,
    output logic [$clog2(N)-1:0] idx
);

    always_comb begin
        any = |req;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = ($clog2(N))'(i);
            end
        end
    end

endmodule : fixed_prio_pick

// ==== hdl/party_line_io.sv ====
// Purpose: Party-line I/O bus master with eight cycle-stealing DMA channels.
// Assumes: Avalon-MM slave with byte addresses; peripherals synchronous to sys_clk.
// Notes: A write to the command register stalls until the instruction ends.
// How it works
// - Bus moves a word between any of 64 devices and 15 general registers.
// - Transfers are paced by device interrupt or by polling device status.
// - Command word holds device, register, direction and information kind.
// - Output instruction takes 1.33 us, input 1.6 us; next may follow at once.
// - Four kinds, status in, data in, command out, data out, for groups A-D.
// - Eight multiplexed channels each move a block between memory and a device.
// - A channel chains into a further block without software help.
// - Channel words share the bus and beat program-controlled transfers.
// - Each requested channel word steals one memory cycle from the processor.
// - Each channel holds a 16-bit next address and a 16-bit remaining count.
// - Channel words are spaced to 412K words/s in and 375K words/s out.
// - External engine uses own memory port, 625K words/s, and the same bus.
// - Software picks which of 64 devices drive each party-line level.
module party_line_io
    import party_line_pkg::*;
#(
    parameter int NCH = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output io_bus_t io_out,
    input wire logic [15:0] io_din,
    input wire logic [63:0] pl_word_req,
    input wire logic [63:0] pl_end_req,
    output logic irq_word,
    output logic irq_end,
    output logic [63:0] conn_word,
    output logic [63:0] conn_end,
    input wire logic [NCH-1:0] dmp_word_req,
    output logic [NCH-1:0] dmp_block_end,
    output mem_req_t mem,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    output logic cpu_steal,
    input wire logic ext_req,
    input wire io_bus_t ext_bus,
    output logic ext_gnt
);

    localparam int SW = $clog2(NCH);

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_PROG = 5'h02,
        S_DMP_BUS = 5'h04,
        S_DMP_MEM = 5'h08,
        S_EXT = 5'h10
    } fsm_t;

    typedef struct packed {
        fsm_t st;
        logic [7:0] timer;
        logic [8:0] gap;
        logic [15:0][15:0] gr;
        logic [63:0] conn_w;
        logic [63:0] conn_e;
        io_bus_t io;
        mem_req_t mem;
        logic cmd_pend;
        logic [13:0] cmd;
        logic resp;
        logic [31:0] rdata;
        logic [15:0] last_din;
        logic [SW-1:0] sel;
        logic dir_in;
        logic [15:0] word;
        logic irq_w;
        logic irq_e;
        logic ext_gnt;
    } main_t;

    main_t q_reg;
    main_t q_next;

    logic [NCH-1:0][15:0] ch_addr;
    logic [NCH-1:0][15:0] ch_count;
    logic [NCH-1:0][10:0] ch_ctrl;
    logic [NCH-1:0] ch_armed;
    logic [NCH-1:0] ch_want;
    logic [NCH-1:0] ch_wr;
    logic [NCH-1:0] step;
    logic pick_any;
    logic [SW-1:0] pick_idx;
    logic [31:0] rd_word;
    logic bus_req;
    logic is_cmd;
    logic in_gr;
    logic in_ch;
    logic [SW-1:0] a_ch;
    logic cmd_is_in;

    // ------------------------------------------------------------
    // Channels and priority pick
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            dmp_channel u_ch (
                .sys_clk(sys_clk),
                .srst(srst),
                .wr(ch_wr[gi]),
                .wr_field(avs_address[4:2]),
                .wr_data(avs_writedata[15:0]),
                .step(step[gi]),
                .addr(ch_addr[gi]),
                .count(ch_count[gi]),
                .ctrl(ch_ctrl[gi]),
                .chain_armed(ch_armed[gi]),
                .block_end(dmp_block_end[gi])
            );
            assign ch_want[gi] = ch_ctrl[gi][CTL_ENABLE] && ch_count[gi] != 16'h0000
                && dmp_word_req[gi];
            assign ch_wr[gi] = bus_req && q_reg.resp && avs_write && in_ch
                && a_ch == SW'(gi);
        end
    endgenerate

    fixed_prio_pick #(.N(NCH)) u_pick (
        .req(ch_want),
        .any(pick_any),
        .idx(pick_idx)
    );

    // ------------------------------------------------------------
    // Address decode and read mux
    // ------------------------------------------------------------
    assign bus_req = avs_read || avs_write;
    assign is_cmd = avs_address == ADDR_IO_CMD;
    assign in_gr = avs_address[11:6] == GR_PAGE;
    assign in_ch = avs_address[11:8] == CH_PAGE && {1'b0, avs_address[7:5]} < 4'(NCH);
    assign a_ch = avs_address[5+:SW];
    assign cmd_is_in = !q_reg.cmd[CMD_KIND_LSB+1];

    always_comb begin
        rd_word = 32'h0000_0000;
        if (is_cmd) begin
            rd_word = {18'h00000, q_reg.cmd};
        end else if (avs_address == ADDR_IO_STAT) begin
            rd_word = {q_reg.cmd_pend, 10'h000, q_reg.st, q_reg.last_din};
        end else if (avs_address == ADDR_CONN_W_LO) begin
            rd_word = q_reg.conn_w[31:0];
        end else if (avs_address == ADDR_CONN_W_HI) begin
            rd_word = q_reg.conn_w[63:32];
        end else if (avs_address == ADDR_CONN_E_LO) begin
            rd_word = q_reg.conn_e[31:0];
        end else if (avs_address == ADDR_CONN_E_HI) begin
            rd_word = q_reg.conn_e[63:32];
        end else if (in_gr) begin
            rd_word = {16'h0000, q_reg.gr[avs_address[5:2]]};
        end else if (in_ch) begin
            unique case (avs_address[4:2])
                CH_ADDR: rd_word = {16'h0000, ch_addr[a_ch]};
                CH_COUNT: rd_word = {16'h0000, ch_count[a_ch]};
                CH_CTRL: rd_word = {ch_armed[a_ch], 20'h00000, ch_ctrl[a_ch]};
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        q_next = q_reg;
        step = '0;
        q_next.resp = 1'b0;
        q_next.io.strobe = 1'b0;
        q_next.ext_gnt = 1'b0;
        if (q_reg.gap != 9'h000) begin
            q_next.gap = q_reg.gap - 9'h001;
        end
        q_next.irq_w = |(pl_word_req & q_reg.conn_w);
        q_next.irq_e = |(pl_end_req & q_reg.conn_e);

        if (bus_req && !q_reg.resp) begin
            q_next.rdata = rd_word;
            if (is_cmd && avs_write) begin
                if (!q_reg.cmd_pend) begin
                    q_next.cmd = avs_writedata[13:0];
                    q_next.cmd_pend = 1'b1;
                end
            end else begin
                q_next.resp = 1'b1;
            end
        end
        if (bus_req && q_reg.resp && avs_write) begin
            if (avs_address == ADDR_CONN_W_LO) q_next.conn_w[31:0] = avs_writedata;
            if (avs_address == ADDR_CONN_W_HI) q_next.conn_w[63:32] = avs_writedata;
            if (avs_address == ADDR_CONN_E_LO) q_next.conn_e[31:0] = avs_writedata;
            if (avs_address == ADDR_CONN_E_HI) q_next.conn_e[63:32] = avs_writedata;
            if (in_gr && avs_address[5:2] != 4'h0) begin
                q_next.gr[avs_address[5:2]] = avs_writedata[15:0];
            end
        end

        unique case (q_reg.st)
            S_IDLE: begin
                if (pick_any && q_reg.gap == 9'h000) begin
                    q_next.sel = pick_idx;
                    q_next.dir_in = ch_ctrl[pick_idx][CTL_DIR_IN];
                    q_next.io.dev = ch_ctrl[pick_idx][CTL_DEV_LSB+:6];
                    q_next.io.group = ch_ctrl[pick_idx][CTL_GRP_LSB+:2];
                    if (ch_ctrl[pick_idx][CTL_DIR_IN]) begin
                        q_next.io.kind = KIND_DATA_IN;
                        q_next.io.strobe = 1'b1;
                        q_next.st = S_DMP_BUS;
                    end else begin
                        q_next.mem = '{req: 1'b1, we: 1'b0, addr: ch_addr[pick_idx],
                            wdata: 16'h0000};
                        q_next.st = S_DMP_MEM;
                    end
                end else if (ext_req && q_reg.gap == 9'h000) begin
                    q_next.ext_gnt = 1'b1;
                    q_next.st = S_EXT;
                end else if (q_reg.cmd_pend) begin
                    q_next.io.dev = q_reg.cmd[CMD_DEV_LSB+:6];
                    q_next.io.group = q_reg.cmd[CMD_GRP_LSB+:2];
                    q_next.io.kind = io_kind_t'(q_reg.cmd[CMD_KIND_LSB+:2]);
                    q_next.io.data = q_reg.gr[q_reg.cmd[CMD_REG_LSB+:4]];
                    q_next.io.strobe = 1'b1;
                    q_next.timer = cmd_is_in ? 8'(IN_CYC - 1) : 8'(OUT_CYC - 1);
                    q_next.st = S_PROG;
                end
            end
            S_PROG: begin
                q_next.timer = q_reg.timer - 8'h01;
                if (q_reg.timer == 8'h00) begin
                    if (cmd_is_in) begin
                        q_next.last_din = io_din;
                        if (q_reg.cmd[CMD_REG_LSB+:4] != 4'h0) begin
                            q_next.gr[q_reg.cmd[CMD_REG_LSB+:4]] = io_din;
                        end
                    end
                    q_next.cmd_pend = 1'b0;
                    q_next.resp = 1'b1;
                    q_next.st = S_IDLE;
                end
            end
            S_DMP_BUS: begin
                if (q_reg.dir_in) begin
                    q_next.word = io_din;
                    q_next.mem = '{req: 1'b1, we: 1'b1, addr: ch_addr[q_reg.sel],
                        wdata: io_din};
                    q_next.st = S_DMP_MEM;
                end else begin
                    step[q_reg.sel] = 1'b1;
                    q_next.gap = DMP_OUT_GAP - 9'h001;
                    q_next.st = S_IDLE;
                end
            end
            S_DMP_MEM: begin
                if (mem_ack) begin
                    q_next.mem.req = 1'b0;
                    if (q_reg.dir_in) begin
                        step[q_reg.sel] = 1'b1;
                        q_next.gap = DMP_IN_GAP - 9'h001;
                        q_next.st = S_IDLE;
                    end else begin
                        q_next.word = mem_rdata;
                        q_next.io.kind = KIND_DATA_OUT;
                        q_next.io.data = mem_rdata;
                        q_next.io.strobe = 1'b1;
                        q_next.st = S_DMP_BUS;
                    end
                end
            end
            S_EXT: begin
                q_next.io = ext_bus;
                q_next.gap = EXT_GAP - 9'h001;
                q_next.st = S_IDLE;
            end
            default: q_next.st = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q_reg <= '{st: S_IDLE, io: '{kind: KIND_STATUS_IN, default: '0}, default: '0};
        end else begin
            q_reg <= q_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_waitrequest = bus_req && !q_reg.resp;
    assign avs_readdata = q_reg.rdata;
    assign io_out = q_reg.io;
    assign irq_word = q_reg.irq_w;
    assign irq_end = q_reg.irq_e;
    assign conn_word = q_reg.conn_w;
    assign conn_end = q_reg.conn_e;
    assign mem = q_reg.mem;
    assign cpu_steal = q_reg.mem.req;
    assign ext_gnt = q_reg.ext_gnt;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_prog_start;
        q_reg.st == S_IDLE && q_next.st == S_PROG;
    endsequence

    property p_out_time;
        @(posedge sys_clk) disable iff (srst)
        (s_prog_start and !cmd_is_in) |=> ##(OUT_CYC) q_reg.resp && q_reg.st == S_IDLE;
    endproperty
    a_out_time: assert property (p_out_time) else $error("output instr time wrong");

    property p_in_time;
        @(posedge sys_clk) disable iff (srst)
        (s_prog_start and cmd_is_in) |=> ##(IN_CYC) q_reg.resp && q_reg.st == S_IDLE;
    endproperty
    a_in_time: assert property (p_in_time) else $error("input instr time wrong");

    property p_dmp_first;
        @(posedge sys_clk) disable iff (srst)
        (q_reg.st == S_IDLE && pick_any && q_reg.gap == 9'h000) |=>
            (q_reg.st != S_PROG) && !q_reg.ext_gnt;
    endproperty
    a_dmp_first: assert property (p_dmp_first) else $error("program beat channel");

    property p_lowest;
        @(posedge sys_clk) disable iff (srst)
        (q_reg.st == S_IDLE && pick_any && q_reg.gap == 9'h000) |=>
            ($past(ch_want) & ((NCH'(1) << q_reg.sel) - NCH'(1))) == '0;
    endproperty
    a_lowest: assert property (p_lowest) else $error("channel order wrong");

    sequence s_in_bus;
        q_reg.st == S_DMP_BUS && q_reg.dir_in;
    endsequence

    property p_steal;
        @(posedge sys_clk) disable iff (srst)
        s_in_bus |=> cpu_steal && mem.we && mem.wdata == $past(io_din);
    endproperty
    a_steal: assert property (p_steal) else $error("no stolen cycle");

    property p_in_rate;
        @(posedge sys_clk) disable iff (srst)
        (q_reg.st == S_DMP_MEM && q_reg.dir_in && mem_ack) |=>
            (q_reg.st == S_IDLE && !cpu_steal) [*8];
    endproperty
    a_in_rate: assert property (p_in_rate) else $error("channel words too close");

    property p_irq_mask;
        @(posedge sys_clk) disable iff (srst)
        ##1 irq_word == |($past(pl_word_req) & $past(q_reg.conn_w));
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("word level not masked");

    property p_prog_bus;
        @(posedge sys_clk) disable iff (srst)
        s_prog_start |=> io_out.strobe && io_out.dev == $past(q_reg.cmd[5:0])
            && io_out.kind == $past(q_reg.cmd[9:8]);
    endproperty
    a_prog_bus: assert property (p_prog_bus) else $error("bus fields wrong");

endmodule : party_line_io

// ==== hdl/party_line_pkg.sv ====
// Purpose: Shared constants and carriers for the party-line I/O block.
// Assumes: 100 MHz sys_clk, byte addresses on the register bus.
// Notes: Timing counts are derived from the printed times and rates.
package party_line_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_NS = 10;
    localparam int OUT_INSTR_NS = 1330;
    localparam int IN_INSTR_NS = 1600;
    localparam int OUT_CYC = (OUT_INSTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int IN_CYC = (IN_INSTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int DMP_IN_WPS = 412_000;
    localparam int DMP_OUT_WPS = 375_000;
    localparam int EXT_WPS = 625_000;
    localparam logic [8:0] DMP_IN_GAP = 9'((CLK_HZ + DMP_IN_WPS - 1) / DMP_IN_WPS);
    localparam logic [8:0] DMP_OUT_GAP = 9'((CLK_HZ + DMP_OUT_WPS - 1) / DMP_OUT_WPS);
    localparam logic [8:0] EXT_GAP = 9'((CLK_HZ + EXT_WPS - 1) / EXT_WPS);

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_IO_CMD = 12'h000;
    localparam logic [11:0] ADDR_IO_STAT = 12'h004;
    localparam logic [11:0] ADDR_CONN_W_LO = 12'h010;
    localparam logic [11:0] ADDR_CONN_W_HI = 12'h014;
    localparam logic [11:0] ADDR_CONN_E_LO = 12'h018;
    localparam logic [11:0] ADDR_CONN_E_HI = 12'h01c;
    localparam logic [5:0] GR_PAGE = 6'h01;
    localparam logic [3:0] CH_PAGE = 4'h1;
    localparam logic [2:0] CH_ADDR = 3'h0;
    localparam logic [2:0] CH_COUNT = 3'h1;
    localparam logic [2:0] CH_CTRL = 3'h2;
    localparam logic [2:0] CH_NADDR = 3'h3;
    localparam logic [2:0] CH_NCOUNT = 3'h4;

    // Command word fields
    localparam int CMD_DEV_LSB = 0;
    localparam int CMD_GRP_LSB = 6;
    localparam int CMD_KIND_LSB = 8;
    localparam int CMD_REG_LSB = 10;

    // Channel control fields
    localparam int CTL_DEV_LSB = 0;
    localparam int CTL_GRP_LSB = 6;
    localparam int CTL_DIR_IN = 8;
    localparam int CTL_ENABLE = 9;
    localparam int CTL_CHAIN = 10;
    localparam logic [10:0] CTL_RESET = 11'h000;

    typedef enum logic [1:0] {
        KIND_STATUS_IN = 2'h0,
        KIND_DATA_IN = 2'h1,
        KIND_CMD_OUT = 2'h2,
        KIND_DATA_OUT = 2'h3
    } io_kind_t;

    typedef struct packed {
        logic strobe;
        io_kind_t kind;
        logic [1:0] group;
        logic [5:0] dev;
        logic [15:0] data;
    } io_bus_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_t;

endpackage : party_line_pkg

// ==== testbench/far_side.sv ====
// Purpose: Peripheral and memory model
// Assumes: Shares sys_clk with the block
// Notes: Memory answers after one or three cycles, in turn
module far_side
    import party_line_pkg::*;
(
    input wire logic sys_clk,
    input wire io_bus_t io_out,
    input wire mem_req_t mem,
    output logic [15:0] io_din,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] ram [0:255];
    logic [1:0] wait_reg = 2'h0;
    logic slow_reg = 1'b0;
    assign io_din = {io_out.dev, 10'h1a5};
    assign mem_rdata = ~mem.addr;
    initial mem_ack = 1'b0;
    always @(posedge sys_clk) begin
        mem_ack <= 1'b0;
        if (mem.req && !mem_ack) begin
            wait_reg <= wait_reg + 2'h1;
            if (wait_reg == {slow_reg, 1'b0}) begin
                mem_ack <= 1'b1;
                wait_reg <= 2'h0;
                slow_reg <= !slow_reg;
                if (mem.we) ram[mem.addr[7:0]] <= mem.wdata;
            end
        end
    end
endmodule : far_side

// ==== testbench/party_line_io_tb_top.sv ====
// Purpose: Self-checking bench for party_line_io
// Assumes: far_side answers memory and device reads
// Notes: Expected results queue up; a watcher pops them
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module party_line_io_tb_top
    import party_line_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, seed = 32'h00015486, e_rd;
    logic avs_waitrequest, irq_word, irq_end, cpu_steal, ext_gnt, mem_ack;
    io_bus_t io_out;
    mem_req_t mem;
    logic [15:0] io_din, mem_rdata, gr;
    logic [63:0] pl_word_req = 64'h0;
    logic [7:0] dmp_word_req = 8'h00, dmp_block_end;
    logic [25:0] e_io;
    logic [31:0] qrd[$];
    logic [25:0] qio[$];
    int fails = 0, n_checks = 0, cyc = 0, ends = 0;
    always #5 sys_clk = ~sys_clk;
    party_line_io dut (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .io_out(io_out),
        .io_din(io_din), .pl_word_req(pl_word_req), .pl_end_req(64'h0), .irq_word(irq_word),
        .irq_end(irq_end), .conn_word(), .conn_end(), .dmp_word_req(dmp_word_req),
        .dmp_block_end(dmp_block_end), .mem(mem), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .cpu_steal(cpu_steal), .ext_req(1'b0), .ext_bus('0), .ext_gnt(ext_gnt));
    far_side u_far (.sys_clk(sys_clk), .io_out(io_out), .mem(mem), .io_din(io_din),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        cyc = 0;
        do begin
            @(posedge sys_clk);
            cyc++;
        end while (avs_waitrequest !== 1'b0 && cyc < 400);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (cyc >= 400) begin fails++; end_of_test(); end
    endtask : bus
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        qrd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && qrd.size() > 0) begin
            e_rd = qrd.pop_front();
            `CHK("readdata", e_rd, avs_readdata)
        end
        if (io_out.strobe === 1'b1) begin
            e_io = qio.size() > 0 ? qio.pop_front() : 26'h0;
            `CHK("io_out", e_io, {io_out.kind, io_out.group, io_out.dev, io_out.kind[1] ? io_out.data : 16'h0})
        end
        if (dmp_block_end[0] === 1'b1) ends++;
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        seed = lfsr(seed);
        gr = seed[15:0];
        bus(1'b1, 12'h044, {16'h0, gr});
        rd(12'h044, {16'h0, gr});
        rd(12'h040, 32'h0);
        rd(12'h020, 32'h0);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            if (!k[1]) gr = {seed[5:0], 10'h1a5};
            qio.push_back({k[1:0], k[1:0], seed[5:0], k[1] ? gr : 16'h0});
            bus(1'b1, ADDR_IO_CMD, {18'h0, 4'h1, k[1:0], k[1:0], seed[5:0]});
            `CHK("instr cycles", (k[1] ? OUT_CYC : IN_CYC) + 3, cyc)
            rd(12'h044, {16'h0, gr});
        end
        $display("io test done");
        bus(1'b1, ADDR_CONN_W_LO, 32'h8);
        pl_word_req <= 64'h9;
        repeat (3) @(posedge sys_clk);
        `CHK("irq on", 1'b1, irq_word)
        bus(1'b1, ADDR_CONN_W_LO, 32'h2);
        repeat (3) @(posedge sys_clk);
        `CHK("irq off", 1'b0, irq_word)
        $display("irq test done");
        qio.push_back({2'h1, 2'h0, 6'h05, 16'h0});
        qio.push_back({2'h1, 2'h0, 6'h05, 16'h0});
        bus(1'b1, 12'h100, 32'h10);
        bus(1'b1, 12'h104, 32'h2);
        bus(1'b1, 12'h108, 32'h305);
        dmp_word_req <= 8'h01;
        for (cyc = 0; cyc < 2000 && ends == 0; cyc++) @(posedge sys_clk);
        dmp_word_req <= 8'h00;
        `CHK("ram lo", {6'h05, 10'h1a5}, u_far.ram[8'h10])
        `CHK("ram hi", {6'h05, 10'h1a5}, u_far.ram[8'h11])
        rd(12'h100, 32'h12);
        rd(12'h104, 32'h0);
        repeat (300) @(posedge sys_clk);
        `CHK("block ends", 1, ends)
        $display("dma test done");
        end_of_test();
    end
endmodule : party_line_io_tb_top
